/* File: src/qdr_phy_pkg.sv */
// constants and types for the quad-data-rate sram data path
package qdr_phy_pkg;
   // bus and sizes
   localparam int addr_w = 8;
   localparam int data_w = 32;
   localparam int grp_w = 36;
   localparam int par_w = 4;
   // register byte offsets
   localparam logic [addr_w-1:0] ctrl_off = 8'h00;
   localparam logic [addr_w-1:0] status_off = 8'h04;
   localparam logic [addr_w-1:0] wdata_off = 8'h08;
   localparam logic [addr_w-1:0] wpar_off = 8'h0c;
   localparam logic [addr_w-1:0] rdata_rise_off = 8'h10;
   localparam logic [addr_w-1:0] rdata_fall_off = 8'h14;
   localparam logic [addr_w-1:0] rpar_off = 8'h18;
   localparam logic [addr_w-1:0] trim_off = 8'h1c;
   // ctrl fields
   localparam int ctrl_en_bit = 0;
   localparam int ctrl_pll_bit = 1;
   localparam int ctrl_mode_lsb = 2;
   localparam int ctrl_phase_lsb = 4;
   localparam int ctrl_wr_bit = 8;
   localparam logic [31:0] ctrl_reset_val = 32'h0000_0000;
   localparam logic [7:0] trim_reset_val = 8'h00;
   // group widths per bus mode
   localparam logic [5:0] width_x4 = 6'h04;
   localparam logic [5:0] width_x9 = 6'h09;
   localparam logic [5:0] width_x18 = 6'h12;
   localparam logic [5:0] width_x36 = 6'h24;
   // phase shift table in tenths of a degree
   localparam int n_phase = 12;
   localparam logic [11:0] phase_tenths [n_phase] = '{
      12'h000, 12'h0e1, 12'h12c, 12'h168, 12'h1c2, 12'h258,
      12'h2a3, 12'h2d0, 12'h384, 12'h438, 12'h4b0, 12'h5a0};
   // bit mask of phases allowed for each of the four delay-loop modes
   localparam logic [11:0] phase_allow [4] = '{12'h111, 12'h94b, 12'h6a5, 12'hfff};
   // read latency in half cycles of the memory clock
   localparam int read_lat_half = 3;
   typedef enum logic [1:0] {bus_x4, bus_x9, bus_x18, bus_x36} bus_mode_t;
   typedef enum logic [1:0] {loop_a, loop_b, loop_c, loop_d} loop_mode_t;
endpackage

/* File: src/qdr_pin_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
module qdr_pin_sync
   import qdr_phy_pkg::*;
#(
   parameter int width = 1
)
(
   // clock
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // pins and filtered level
   input wire logic [width-1:0] pin,
   output logic [width-1:0] level
);
   typedef struct packed {
      logic [width-1:0] s1;
      logic [width-1:0] s2;
      logic [width-1:0] s3;
      logic [width-1:0] lvl;
   } sync_t;
   sync_t st_q, st_d;
   always_comb
   begin
      st_d = st_q;
      st_d.s1 = pin;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < width; i++)
      begin
         if (st_q.s2[i] == st_q.s3[i])
         begin
            st_d.lvl[i] = st_q.s3[i];
         end
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= '0;
      end
      else if (ce)
      begin
         st_q <= st_d;
      end
   end
   assign level = st_q.lvl;
endmodule

/* File: src/qdr_strobe_delay.sv */
// per-strobe delay line with shared coarse setting and own fine trim
module qdr_strobe_delay
   import qdr_phy_pkg::*;
(
   // clock
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // shared control word and own trim
   input wire logic [3:0] coarse,
   input wire logic [3:0] fine,
   // strobe in and delayed strobe
   input wire logic strobe_in,
   output logic strobe_out
);
   typedef struct packed {
      logic [31:0] line;
   } dly_t;
   dly_t st_q, st_d;
   logic [4:0] tap;
   always_comb
   begin
      st_d = st_q;
      st_d.line = {st_q.line[30:0], strobe_in};
      tap = 5'(coarse) + 5'(fine);
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= '0;
      end
      else if (ce)
      begin
         st_q <= st_d;
      end
   end
   assign strobe_out = st_q.line[tap];
endmodule

/* File: src/qdr_sram_phy_datapath.sv */
// quad-data-rate sram data path with axi4-lite control
//
// Chosen here: the AXI4-Lite register port and the register addresses.
module qdr_sram_phy_datapath
   import qdr_phy_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write address
   input wire logic [addr_w-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [data_w-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [addr_w-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [data_w-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // echo clock pins
   input wire logic strobe_pin_i,
   output logic strobe_pin_o,
   output logic strobe_pin_oe,
   input wire logic strobe_complement_pin_i,
   output logic strobe_complement_pin_o,
   output logic strobe_complement_pin_oe,
   // read data pins
   input wire logic [grp_w-1:0] read_data_pin,
   // read pll clock
   input wire logic rd_pll_clk,
   // write side pins
   output logic [grp_w-1:0] write_data_pin,
   output logic mem_clk_p,
   output logic mem_clk_n,
   // frequency reference, write clock
   input wire logic freq_ref,
   input wire logic write_clk,
   // unused group pins for general purpose use
   output logic [grp_w-1:0] gpio_free
);
   typedef enum {wr_idle, wr_resp} wr_state_t;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [7:0] trim_true;
      logic [7:0] trim_comp;
      logic [grp_w-1:0] wword;
      logic [grp_w-1:0] rise_cap;
      logic [grp_w-1:0] fall_cap;
      logic [grp_w-1:0] rise_pair;
      logic [grp_w-1:0] fall_pair;
      logic pair_new;
      logic [grp_w-1:0] wr_out;
      logic wr_phase;
      logic [1:0] wr_clk_hist;
      logic [1:0] str_hist;
      logic [1:0] cmp_hist;
      logic [1:0] pll_hist;
      logic [1:0] ref_hist;
      logic [7:0] ref_cnt;
      logic [7:0] ref_period;
      logic [3:0] coarse;
      logic [5:0] captures;
      logic awdone;
      logic wdone;
      logic [addr_w-1:0] awaddr;
      logic [data_w-1:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [data_w-1:0] rdata;
      logic [1:0] rresp;
   } st_t;
   st_t st_q, st_d;
   logic str_lvl, cmp_lvl, pll_lvl, ref_lvl, wck_lvl;
   logic str_dly, cmp_dly;
   logic [grp_w-1:0] rd_lvl;
   logic [5:0] grp_width;
   logic [grp_w-1:0] grp_mask;
   logic [3:0] phase_sel;
   logic phase_ok;
   logic [31:0] wr_merged;
   // pin synchronisers, strobe pair kept separate
   qdr_pin_sync #(.width(5)) u_clk_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .pin({strobe_pin_i, strobe_complement_pin_i, rd_pll_clk, freq_ref, write_clk}),
      .level({str_lvl, cmp_lvl, pll_lvl, ref_lvl, wck_lvl})
   );
   qdr_pin_sync #(.width(grp_w)) u_data_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .pin(read_data_pin),
      .level(rd_lvl)
   );
   // each strobe has its own delay line
   qdr_strobe_delay u_dly_true (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .coarse(st_q.coarse),
      .fine(st_q.trim_true[3:0]),
      .strobe_in(str_lvl),
      .strobe_out(str_dly)
   );
   qdr_strobe_delay u_dly_comp (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .coarse(st_q.coarse),
      .fine(st_q.trim_comp[3:0]),
      .strobe_in(cmp_lvl),
      .strobe_out(cmp_dly)
   );
   always_comb
   begin
      // group width per bus mode
      case (bus_mode_t'(st_q.ctrl[ctrl_mode_lsb +: 2]))
         bus_x4: grp_width = width_x4;
         bus_x9: grp_width = width_x9;
         bus_x18: grp_width = width_x18;
         bus_x36: grp_width = width_x36;
         default: grp_width = width_x4;
      endcase
      grp_mask = '0;
      for (int i = 0; i < grp_w; i++)
      begin
         grp_mask[i] = (6'(i) < grp_width);
      end
      // phase choice checked against loop mode
      phase_sel = st_q.ctrl[ctrl_phase_lsb +: 4];
      phase_ok = (phase_sel < 4'(n_phase)) &&
         phase_allow[st_q.ctrl[ctrl_mode_lsb +: 2]][phase_sel];
      wr_merged = st_q.wdata;
      for (int b = 0; b < 4; b++)
      begin
         if (!st_q.wstrb[b])
         begin
            wr_merged[b*8 +: 8] = 8'h00;
         end
      end
   end
   always_comb
   begin
      st_d = st_q;
      st_d.str_hist = {st_q.str_hist[0], str_dly};
      st_d.cmp_hist = {st_q.cmp_hist[0], cmp_dly};
      st_d.pll_hist = {st_q.pll_hist[0], pll_lvl};
      st_d.ref_hist = {st_q.ref_hist[0], ref_lvl};
      st_d.wr_clk_hist = {st_q.wr_clk_hist[0], wck_lvl};
      st_d.pair_new = 1'b0;
      // delay control tracked from reference period
      st_d.ref_cnt = st_q.ref_cnt + 8'h01;
      if (st_q.ref_hist == 2'b01)
      begin
         st_d.ref_period = st_q.ref_cnt;
         st_d.ref_cnt = 8'h00;
      end
      if (phase_ok)
      begin
         st_d.coarse = 4'(({4'h0, st_q.ref_period} *
            {12'h000, phase_tenths[phase_sel][11:8]}) >> 6);
      end
      if (st_q.ctrl[ctrl_en_bit])
      begin
         if (st_q.ctrl[ctrl_pll_bit])
         begin
            // pll clock drives both ddr capture edges
            if (st_q.pll_hist == 2'b01)
            begin
               st_d.rise_cap = rd_lvl & grp_mask;
            end
            if (st_q.pll_hist == 2'b10)
            begin
               st_d.fall_cap = rd_lvl & grp_mask;
               st_d.pair_new = 1'b1;
            end
         end
         else
         begin
            // true echo rises into high capture, complement into low
            if (st_q.str_hist == 2'b01)
            begin
               st_d.rise_cap = rd_lvl & grp_mask;
            end
            if (st_q.cmp_hist == 2'b01)
            begin
               st_d.fall_cap = rd_lvl & grp_mask;
               st_d.pair_new = 1'b1;
            end
         end
      end
      // register the captured words as one pair
      if (st_q.pair_new)
      begin
         st_d.rise_pair = st_q.rise_cap;
         st_d.fall_pair = st_q.fall_cap;
         st_d.captures = st_q.captures + 6'h01;
      end
      // write launched on rising write clock edges, independent of reads
      if (st_q.wr_clk_hist == 2'b01)
      begin
         st_d.wr_phase = 1'b1;
         if (st_q.ctrl[ctrl_wr_bit])
         begin
            st_d.wr_out = st_q.wword & grp_mask;
         end
      end
      if (st_q.wr_clk_hist == 2'b10)
      begin
         st_d.wr_phase = 1'b0;
      end
      // axi write channels, taken in either order
      if (s_axi_awvalid && !st_q.awdone)
      begin
         st_d.awdone = 1'b1;
         st_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_q.wdone)
      begin
         st_d.wdone = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
      end
      if (st_q.awdone && st_q.wdone && !st_q.bvalid)
      begin
         st_d.bvalid = 1'b1;
         st_d.bresp = 2'b00;
         case ({st_q.awaddr[addr_w-1:2], 2'b00})
            ctrl_off: st_d.ctrl = (st_q.ctrl & ~wr_merged) | wr_merged;
            wdata_off: st_d.wword[31:0] = wr_merged;
            wpar_off: st_d.wword[grp_w-1:32] = wr_merged[par_w-1:0];
            trim_off:
            begin
               st_d.trim_true = {4'h0, wr_merged[3:0]};
               st_d.trim_comp = {4'h0, wr_merged[11:8]};
            end
            status_off, rdata_rise_off, rdata_fall_off, rpar_off: st_d.bresp = 2'b00;
            default: st_d.bresp = 2'b10;
         endcase
         if ({st_q.awaddr[addr_w-1:2], 2'b00} == ctrl_off)
         begin
            for (int b = 0; b < 4; b++)
            begin
               if (st_q.wstrb[b])
               begin
                  st_d.ctrl[b*8 +: 8] = st_q.wdata[b*8 +: 8];
               end
            end
         end
      end
      if (st_q.bvalid && s_axi_bready)
      begin
         st_d.bvalid = 1'b0;
         st_d.awdone = 1'b0;
         st_d.wdone = 1'b0;
      end
      // axi read
      if (s_axi_arvalid && !st_q.rvalid)
      begin
         st_d.rvalid = 1'b1;
         st_d.rresp = 2'b00;
         case ({s_axi_araddr[addr_w-1:2], 2'b00})
            ctrl_off: st_d.rdata = st_q.ctrl;
            status_off: st_d.rdata = {16'h0000, 2'b00, st_q.captures,
               3'b000, phase_ok, st_q.coarse};
            wdata_off: st_d.rdata = st_q.wword[31:0];
            wpar_off: st_d.rdata = {28'h0000000, st_q.wword[grp_w-1:32]};
            rdata_rise_off: st_d.rdata = st_q.rise_pair[31:0];
            rdata_fall_off: st_d.rdata = st_q.fall_pair[31:0];
            rpar_off: st_d.rdata = {24'h000000, st_q.fall_pair[grp_w-1:32],
               st_q.rise_pair[grp_w-1:32]};
            trim_off: st_d.rdata = {20'h00000, st_q.trim_comp[3:0], 4'h0,
               st_q.trim_true[3:0]};
            default:
            begin
               st_d.rdata = 32'h0000_0000;
               st_d.rresp = 2'b10;
            end
         endcase
      end
      if (st_q.rvalid && s_axi_rready)
      begin
         st_d.rvalid = 1'b0;
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= '0;
         st_q.ctrl <= ctrl_reset_val;
         st_q.trim_true <= trim_reset_val;
         st_q.trim_comp <= trim_reset_val;
      end
      else if (ce)
      begin
         st_q <= st_d;
      end
   end
   // axi outputs
   assign s_axi_awready = !st_q.awdone;
   assign s_axi_wready = !st_q.wdone;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = !st_q.rvalid;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;
   // echo pins are inputs only
   assign strobe_pin_o = 1'b0;
   assign strobe_pin_oe = 1'b0;
   assign strobe_complement_pin_o = 1'b0;
   assign strobe_complement_pin_oe = 1'b0;
   // single-clock mode: memory clock pair from the synchronised write clock edges, gated by the enable bit
   assign mem_clk_p = st_q.wr_phase & st_q.ctrl[ctrl_en_bit];
   assign mem_clk_n = ~st_q.wr_phase & st_q.ctrl[ctrl_en_bit];
   assign write_data_pin = st_q.wr_out & grp_mask;
   // pins outside the group are released
   assign gpio_free = ~grp_mask;
endmodule

/* File: verification/qdr_phy_checker.sv */
// port assertions for the qdr sram data path
module qdr_phy_checker
   import qdr_phy_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [data_w-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins
   input wire logic strobe_pin_o,
   input wire logic strobe_pin_oe,
   input wire logic strobe_complement_pin_o,
   input wire logic strobe_complement_pin_oe,
   input wire logic [grp_w-1:0] write_data_pin,
   input wire logic [grp_w-1:0] gpio_free
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // handshake steps
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence r_done;
      ar_taken ##1 s_axi_rvalid && s_axi_rready;
   endsequence
   a_oe_off: assert property (!strobe_pin_oe && !strobe_complement_pin_oe)
      else $error("strobe output enable active");
   a_pin_quiet: assert property (!strobe_pin_o && !strobe_complement_pin_o)
      else $error("strobe pin driven");
   a_free_disjoint: assert property ((write_data_pin & gpio_free) == '0)
      else $error("free pin carries write data");
   a_group_width: assert property (gpio_free == ~36'hf || gpio_free == ~36'h1ff
      || gpio_free == ~36'h3ffff || gpio_free == '0)
      else $error("group width not a bus mode");
   a_bvalid_answer: assert property (wr_taken |=> !s_axi_awready ##1 s_axi_bvalid && !s_axi_awready)
      else $error("write answer missing");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_rvalid_answer: assert property (ar_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer missing");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   a_read_close: assert property (r_done |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not closed");
endmodule

/* File: verification/qdr_sram_model.sv */
// behavioural echo clock and read data source of the sram
module qdr_sram_model
(
   // read request and words
   input wire logic go,
   input wire logic fwd,
   input wire logic [35:0] rise_word,
   input wire logic [35:0] fall_word,
   // memory input clock and write data
   input wire logic k,
   input wire logic [35:0] d,
   // echo pair and read data
   output logic cq,
   output logic cq_n,
   output logic [35:0] q
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [35:0] wr_word;
   initial
   begin
      cq = 1'b0;
      cq_n = 1'b1;
      q = '0;
      wr_word = '0;
   end
   // burst of two: write word taken on the falling input clock edge
   always @(negedge k)
   begin
      wr_word = d;
   end
   // read command taken on the rising edge, link period 160 ns
   always @(posedge go)
   begin
      #240;
      q = fwd ? wr_word : rise_word;
      cq = 1'b1;
      cq_n = 1'b0;
      #80;
      q = fall_word;
      cq = 1'b0;
      cq_n = 1'b1;
      #80;
      q = ~fall_word;
   end
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the qdr sram data path
module testbench
   import qdr_phy_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
   logic aclk = 0, aresetn = 0, ce = 1, go = 0, freq_ref = 0, write_clk = 0, fwd = 0;
   logic [addr_w-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [data_w-1:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, strobe_pin_o, strobe_pin_oe, strobe_complement_pin_o;
   logic strobe_complement_pin_oe, mem_clk_p, mem_clk_n;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [35:0] rw = '0, fw = '0, write_data_pin, gpio_free;
   wire logic strobe_pin_i, strobe_complement_pin_i, rd_pll_clk;
   wire logic [35:0] read_data_pin;
   int fail_count = 0, n_tests = 0;
   logic [5:0] wd [4] = '{width_x4, width_x9, width_x18, width_x36};
   row_t rows [5] = '{'{ctrl_off, 32'h10d, 32'h10d, 2'h0}, '{trim_off, 32'hf0a, 32'hf0a, 2'h0},
      '{wpar_off, 32'h5, 32'h5, 2'h0}, '{8'h20, 32'h1, 32'h0, 2'h2},
      '{rdata_rise_off, 32'hffff_ffff, 32'h0, 2'h0}};
   assign rd_pll_clk = strobe_pin_i;
   always #2.5 aclk = ~aclk;
   always #80 write_clk = ~write_clk;
   always #40 freq_ref = ~freq_ref;
   qdr_sram_phy_datapath DUT (.*);
   qdr_sram_model mem (.go(go), .fwd(fwd), .rise_word(rw), .fall_word(fw),
      .k(mem_clk_p), .d(write_data_pin), .cq(strobe_pin_i),
      .cq_n(strobe_complement_pin_i), .q(read_data_pin));
   task automatic print_verdict;
      if (fail_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [35:0] seen, input logic [35:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid && n < 50);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (!s_axi_bvalid)
      begin
         fail_count++;
         print_verdict();
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid && n < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (!s_axi_rvalid)
      begin
         fail_count++;
         print_verdict();
      end
   endtask
   task automatic burst(input logic [31:0] c, input logic [35:0] a, input logic [35:0] b);
      logic [31:0] d;
      logic [1:0] r;
      int i;
      wr(ctrl_off, c, r);
      rw <= fwd ? ~a : a;
      fw <= b;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      for (i = 0; i < 60 && d !== a[31:0]; i++)
         rd(rdata_rise_off, d, r);
      cmp("rise", 36'(d), 36'(a[31:0]));
      rd(rdata_fall_off, d, r);
      cmp("fall", 36'(d), 36'(b[31:0]));
      rd(rpar_off, d, r);
      cmp("par", 36'(d[7:0]), 36'({b[35:32], a[35:32]}));
   endtask
   initial
   begin
      logic [31:0] d;
      logic [1:0] r, r2;
      int i, m, p;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      cmp("awready", 36'(s_axi_awready), 36'h1);
      cmp("free", gpio_free, ~36'hf);
      cmp("oe", 36'({strobe_pin_oe, strobe_complement_pin_oe}), 36'h0);
      foreach (rows[k])
      begin
         wr(rows[k].a, rows[k].d, r);
         cmp("bresp", 36'(r), 36'(rows[k].r));
         rd(rows[k].a, d, r);
         cmp("rdata", 36'(d), 36'(rows[k].e));
         cmp("rresp", 36'(r), 36'(rows[k].r));
      end
      fork
         wr(wpar_off, 32'h3, r);
         rd(trim_off, d, r2);
      join
      cmp("trim", 36'(d), 36'hf0a);
      rd(wpar_off, d, r);
      cmp("wpar", 36'(d), 36'h3);
      for (m = 0; m < 4; m++)
      begin
         for (p = 0; p < n_phase; p++)
         begin
            wr(ctrl_off, 32'((p << 4) | (m << 2)), r);
            rd(status_off, d, r);
            cmp("legal", 36'(d[4]), 36'(phase_allow[m][p]));
         end
         cmp("free", gpio_free, ~((36'h1 << wd[m]) - 36'h1));
      end
      cmp("coarse", 36'(d[3:0]), 36'h1);
      wr(ctrl_off, 32'h105, r);
      wr(wdata_off, 32'hffff_ffff, r);
      wr(wpar_off, 32'hf, r);
      for (i = 0; i < 200 && write_data_pin !== 36'h1ff; i++) @(posedge aclk);
      cmp("wdata pins", write_data_pin, 36'h1ff);
      for (i = 0; i < 200 && mem_clk_p !== 1'b1; i++) @(posedge aclk);
      cmp("clk pair", 36'({mem_clk_p, mem_clk_n}), 36'h2);
      wr(trim_off, 32'h0, r);
      burst(32'h0d, 36'h9_a5a5_1234, 36'h6_5a5a_edcb);
      burst(32'h0f, 36'h3_0f0f_c3c3, 36'hc_f0f0_3c3c);
      fwd <= 1'b1;
      burst(32'h0d, 36'h0_0000_01ff, 36'h5_1234_5678);
      print_verdict();
   end
endmodule
bind qdr_sram_phy_datapath qdr_phy_checker chk_i (.*);
